// ---- pkg/fsq_consts.svh ----
// register addresses, keys, command codes, qualifiers and field positions
`ifndef FSQ_CONSTS_SVH
`define FSQ_CONSTS_SVH
`define FSQ_A_KEY1     8'h97
`define FSQ_A_KEY2     8'hc4
`define FSQ_A_CMD      8'hb2
`define FSQ_A_CONF     8'hb1
`define FSQ_A_ALO      8'hb4
`define FSQ_A_AHI      8'hb5
`define FSQ_A_DATA     8'hb6
`define FSQ_A_STAT     8'hb7
`define FSQ_KEY1_VAL   8'ha2
`define FSQ_KEY2_VAL   8'hdf
`define FSQ_DKEY       8'h55
`define FSQ_C_CHIP     7'h01
`define FSQ_C_SECURE   7'h03
`define FSQ_C_DISABLE  7'h05
`define FSQ_C_MODE     7'h08
`define FSQ_C_SETVEC   7'h09
`define FSQ_C_SECT     7'h0b
`define FSQ_C_VERIFY   7'h0c
`define FSQ_C_PART0    7'h0d
`define FSQ_C_PROG     7'h0e
`define FSQ_AH_SEC0    8'h90
`define FSQ_AH_SEC4    8'h94
`define FSQ_AH_DIS0    8'hb0
`define FSQ_AH_DIS3    8'hb3
`define FSQ_AH_CLKDBL  8'he0
`define FSQ_AH_BUSER   8'he1
`define FSQ_AH_BZERO   8'he2
`define FSQ_AH_SETVEC  8'hf0
`define FSQ_CONF_EN    6
`define FSQ_STAT_BUSY  0
`define FSQ_STAT_REF   1
`define FSQ_REG_RST    8'h00
`define FSQ_LOCK_RST   5'h1f
`define FSQ_SECT_MASK  16'hff80
`endif

// ---- pkg/fsq_pkg.sv ----
// types shared by the flash command sequencer
package fsq_pkg;
  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_KEY1  = 5'h02,
    ST_KEY2  = 5'h04,
    ST_FLASH = 5'h08,
    ST_CFG   = 5'h10
  } fsq_state_t;
  typedef enum logic [2:0] {
    FOP_NONE  = 3'h0,
    FOP_CHIP  = 3'h1,
    FOP_PART0 = 3'h2,
    FOP_SECT  = 3'h3,
    FOP_PROG  = 3'h4,
    FOP_READ  = 3'h5
  } fsq_flop_t;
  typedef enum logic [3:0] {
    CMD_NONE = 4'h0, CMD_CHIP = 4'h1, CMD_PART0 = 4'h2, CMD_SECT = 4'h3,
    CMD_PROG = 4'h4, CMD_VERIFY = 4'h5, CMD_SECURE = 4'h6, CMD_DISABLE = 4'h7,
    CMD_CLKDBL = 4'h8, CMD_BUSER = 4'h9, CMD_BZERO = 4'ha, CMD_SETVEC = 4'hb
  } fsq_cmd_t;
  typedef enum logic [1:0] {
    BOOT_DEF  = 2'h0,
    BOOT_USER = 2'h1,
    BOOT_ZERO = 2'h2
  } fsq_boot_t;
endpackage : fsq_pkg

// ---- pkg/fsq_cfg_if.sv ----
// link between the sequencer and the configuration store
`timescale 1ns/1ns
interface fsq_cfg_if;
  import fsq_pkg::*;
  logic        apply;
  fsq_cmd_t    cmd;
  logic [7:0]  addr_high;
  logic [7:0]  data;
  logic [4:0]  lock_n;
  logic [3:0]  ext_dis;
  logic        clk6;
  fsq_boot_t   boot;
  logic [15:0] boot_addr;
  modport seq (output apply, cmd, addr_high, data,
               input lock_n, ext_dis, clk6, boot, boot_addr);
  modport store (input apply, cmd, addr_high, data,
                 output lock_n, ext_dis, clk6, boot, boot_addr);
endinterface : fsq_cfg_if

// ---- design/fsq_cfg_store.sv ----
// page locks, host disables, clock mode and boot selection
`timescale 1ns/1ns
`include "fsq_consts.svh"
module fsq_cfg_store #(
  parameter logic [15:0] DEFAULT_VECTOR = 16'h4000
) (
  input wire logic CLK,
  input wire logic SRST,
  fsq_cfg_if.store cfg
);
  import fsq_pkg::*;

  logic [4:0]  lock_n_q;
  logic [3:0]  dis_q;
  logic        clk6_q;
  fsq_boot_t   boot_q;
  logic [7:0]  vec_q;
  logic [15:0] baddr_q;
  logic [7:0]  sec_off;
  logic [7:0]  dis_off;

  assign sec_off = cfg.addr_high - `FSQ_AH_SEC0;
  assign dis_off = cfg.addr_high - `FSQ_AH_DIS0;

  // reset stands for the factory state of the stored bits
  always_ff @(posedge CLK)
  begin
    if (SRST)
      lock_n_q <= `FSQ_LOCK_RST;
    else if (cfg.apply)
      case (cfg.cmd)
        CMD_CHIP:   lock_n_q <= `FSQ_LOCK_RST;
        CMD_PART0:  lock_n_q[3:0] <= 4'hf;
        CMD_SECURE: lock_n_q[sec_off[2:0]] <= 1'b0;
        default:    ;
      endcase
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      dis_q  <= 4'h0;
      clk6_q <= 1'b0;
      boot_q <= BOOT_DEF;
      vec_q  <= 8'h00;
    end
    else if (cfg.apply)
      case (cfg.cmd)
        CMD_CHIP:
        begin
          dis_q  <= 4'h0;
          boot_q <= BOOT_DEF;
          vec_q  <= 8'h00;
        end
        CMD_DISABLE: dis_q[dis_off[1:0]] <= 1'b1;
        CMD_CLKDBL:  clk6_q <= 1'b1;
        CMD_BUSER:   boot_q <= BOOT_USER;
        CMD_BZERO:   boot_q <= BOOT_ZERO;
        CMD_SETVEC:  vec_q <= cfg.data;
        default:     ;
      endcase
  end

  // one cycle behind the selection, so the fetch path sees a clean register
  always_ff @(posedge CLK)
  begin
    if (SRST)
      baddr_q <= DEFAULT_VECTOR;
    else if (boot_q == BOOT_USER)
      baddr_q <= {vec_q, 8'h00};
    else if (boot_q == BOOT_ZERO)
      baddr_q <= 16'h0000;
    else
      baddr_q <= DEFAULT_VECTOR;
  end

  assign cfg.lock_n    = lock_n_q;
  assign cfg.ext_dis   = dis_q;
  assign cfg.clk6      = clk6_q;
  assign cfg.boot      = boot_q;
  assign cfg.boot_addr = baddr_q;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);

  property p_chip_boot;
    cfg.apply && cfg.cmd == CMD_CHIP |-> ##2 baddr_q == DEFAULT_VECTOR && lock_n_q == 5'h1f;
  endproperty
  a_chip_boot: assert property (p_chip_boot) else $error("chip erase left config");

  property p_part0;
    cfg.apply && cfg.cmd == CMD_PART0 |=> lock_n_q[3:0] == 4'hf
      && lock_n_q[4] == $past(lock_n_q[4]);
  endproperty
  a_part0: assert property (p_part0) else $error("partition erase locks wrong");

  property p_lock_mono;
    !(cfg.apply && (cfg.cmd == CMD_CHIP || cfg.cmd == CMD_PART0))
      |=> (lock_n_q & ~$past(lock_n_q)) == 5'h00;
  endproperty
  a_lock_mono: assert property (p_lock_mono) else $error("lock bit unlocked");

  property p_secure;
    cfg.apply && cfg.cmd == CMD_SECURE |=> !lock_n_q[$past(sec_off[2:0])];
  endproperty
  a_secure: assert property (p_secure) else $error("page not locked");

  property p_uservec;
    cfg.apply && cfg.cmd == CMD_SETVEC |=> vec_q == $past(cfg.data);
  endproperty
  a_uservec: assert property (p_uservec) else $error("boot vector not stored");
endmodule : fsq_cfg_store

// ---- design/fsq_iap_sequencer.sv ----
// self-programming command sequencer for the on-chip program flash
//
// Contract
// - keys and command come back to back; any other write voids the feed
// - operations start only on a command write in self-programming mode
// - a command without a valid feed is ignored; only the refused status bit is set
// - commands are ignored until the enable bit 6 of configuration is set
// - the cpu is held while an operation runs and released when done
// - sector erase, program and verify refused on a locked page
// - code 01h with data 55h erases both partitions, only with the pin low
// - chip erase ignores locks, clears locks, host disables and boot vector
// - after chip erase boot goes to the default vector
// - code 0dh with 55h erases partition 0 and unlocks pages 0 to 3
// - code 0bh erases the 128-byte sector named by the address registers
// - code 0eh programs the data register value at the address registers
// - code 0ch reads the addressed byte back into the data register
// - code 03h with 90h to 94h locks page 0 to 4, one page each
// - lock bits leave the factory unlocked and only move towards locked, except on chip or partition 0 erase
// - code 08h with e0h selects six clocks per machine cycle
// - code 05h with b0h to b3h disables one external host function each
// - code 08h with e1h boots from user vector, e2h from address zero
// - code 09h with f0h stores the data register as the user boot vector
`timescale 1ns/1ns
`include "fsq_consts.svh"
module fsq_selfprog_sequencer #(
  parameter int PRIMARY_BYTES = 16384
) (
  input  wire logic              CLK,
  input  wire logic              SRST,
  input  wire logic [7:0]        SFR_ADDR,
  input  wire logic              SFR_WR,
  input  wire logic [7:0]        SFR_WDATA,
  output logic [7:0]             SFR_RDATA,
  input  wire logic              EXTERNAL_ACCESS_PIN_N,
  output logic                   CPU_HOLD,
  output logic                   FL_REQ,
  output fsq_pkg::fsq_flop_t     FL_OP,
  output logic [15:0]            FL_ADDR,
  output logic [7:0]             FL_WDATA,
  input  wire logic              FL_DONE,
  input  wire logic [7:0]        FL_RDATA,
  output logic [4:0]             PAGE_LOCK_N,
  output logic [3:0]             EXT_DISABLE,
  output logic                   CLOCK_DOUBLE,
  output fsq_pkg::fsq_boot_t     BOOT_MODE,
  output logic [15:0]            BOOT_ADDR
);
  import fsq_pkg::*;

  localparam int PAGE_SHIFT = $clog2(PRIMARY_BYTES) - 2;

  fsq_state_t  state_q;
  logic [7:0]  cmd_q;
  logic [7:0]  data_q;
  logic [7:0]  ahi_q;
  logic [7:0]  alo_q;
  logic [7:0]  conf_q;
  logic [7:0]  rdata_q;
  logic        ea_n_m;
  logic        ea_n_s;
  logic        hold_q;
  logic        req_q;
  logic        refused_q;
  fsq_flop_t   op_q;
  logic [15:0] fladdr_q;
  logic [7:0]  flwdata_q;
  fsq_cmd_t    kind_q;
  logic        apply_q;
  fsq_cmd_t    apply_cmd_q;
  fsq_cmd_t    new_cmd;
  logic [15:0] addr;
  logic        wr_cmd;
  logic        key1_ok;
  logic        key2_ok;
  logic        locked;
  logic        needs_lock;
  logic        is_flash;
  logic        accept;
  logic        go;
  logic        op_end;

  fsq_cfg_if cfg ();

  fsq_cfg_store #(
    .DEFAULT_VECTOR (16'(PRIMARY_BYTES))
  ) u_store (
    .CLK  (CLK),
    .SRST (SRST),
    .cfg  (cfg)
  );

  function automatic logic [2:0] page_of(input logic [15:0] a);
    if (32'(a) >= 32'(PRIMARY_BYTES))
      page_of = 3'h4;
    else
      page_of = 3'(a >> PAGE_SHIFT);
  endfunction : page_of

  // erase, lock, disable, mode and vector codes count only with their exact qualifier; 0bh, 0ch and 0eh take none; everything else is no command
  function automatic fsq_cmd_t decode(input logic [6:0] c, input logic [7:0] d,
                                      input logic [7:0] h);
    decode = CMD_NONE;
    case (c)
      `FSQ_C_CHIP:    if (d == `FSQ_DKEY) decode = CMD_CHIP;
      `FSQ_C_PART0:   if (d == `FSQ_DKEY) decode = CMD_PART0;
      `FSQ_C_SECT:    decode = CMD_SECT;
      `FSQ_C_PROG:    decode = CMD_PROG;
      `FSQ_C_VERIFY:  decode = CMD_VERIFY;
      `FSQ_C_SECURE:  if (h >= `FSQ_AH_SEC0 && h <= `FSQ_AH_SEC4) decode = CMD_SECURE;
      `FSQ_C_DISABLE: if (h >= `FSQ_AH_DIS0 && h <= `FSQ_AH_DIS3) decode = CMD_DISABLE;
      `FSQ_C_MODE:
        if (h == `FSQ_AH_CLKDBL)
          decode = CMD_CLKDBL;
        else if (h == `FSQ_AH_BUSER)
          decode = CMD_BUSER;
        else if (h == `FSQ_AH_BZERO)
          decode = CMD_BZERO;
      `FSQ_C_SETVEC:  if (h == `FSQ_AH_SETVEC) decode = CMD_SETVEC;
      default:        decode = CMD_NONE;
    endcase
  endfunction : decode

  assign addr       = {ahi_q, alo_q};
  assign wr_cmd     = SFR_WR && SFR_ADDR == `FSQ_A_CMD;
  assign key1_ok    = SFR_WR && SFR_ADDR == `FSQ_A_KEY1 && SFR_WDATA == `FSQ_KEY1_VAL;
  assign key2_ok    = SFR_WR && SFR_ADDR == `FSQ_A_KEY2 && SFR_WDATA == `FSQ_KEY2_VAL;
  assign new_cmd    = decode(SFR_WDATA[6:0], data_q, ahi_q);
  assign locked     = !cfg.lock_n[page_of(addr)];
  assign needs_lock = new_cmd == CMD_SECT || new_cmd == CMD_PROG || new_cmd == CMD_VERIFY;
  assign is_flash   = new_cmd == CMD_CHIP || new_cmd == CMD_PART0 || needs_lock;
  assign accept     = conf_q[`FSQ_CONF_EN]
                      && new_cmd != CMD_NONE
                      && !(needs_lock && locked)
                      && !(new_cmd == CMD_CHIP && ea_n_s);
  assign go         = state_q == ST_KEY2 && wr_cmd && accept;
  assign op_end     = state_q == ST_FLASH && FL_DONE;

  // pin crosses in from the board, so two stages before anything reads it
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      ea_n_m <= 1'b1;
      ea_n_s <= 1'b1;
    end
    else
    begin
      ea_n_m <= EXTERNAL_ACCESS_PIN_N;
      ea_n_s <= ea_n_m;
    end
  end

  // a stray write of any kind between the steps voids the feed
  always_ff @(posedge CLK)
  begin
    if (SRST)
      state_q <= ST_IDLE;
    else
      case (state_q)
        ST_IDLE:
          if (key1_ok)
            state_q <= ST_KEY1;
        ST_KEY1:
          if (key2_ok)
            state_q <= ST_KEY2;
          else if (SFR_WR)
            state_q <= key1_ok ? ST_KEY1 : ST_IDLE;
        ST_KEY2:
          if (go)
            state_q <= is_flash ? ST_FLASH : ST_CFG;
          else if (SFR_WR)
            state_q <= key1_ok ? ST_KEY1 : ST_IDLE;
        ST_FLASH:
          if (FL_DONE)
            state_q <= ST_IDLE;
        ST_CFG:
          state_q <= ST_IDLE;
        default:
          state_q <= ST_IDLE;
      endcase
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
      hold_q <= 1'b0;
    else if (go)
      hold_q <= 1'b1;
    else if (op_end || state_q == ST_CFG)
      hold_q <= 1'b0;
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      req_q     <= 1'b0;
      op_q      <= FOP_NONE;
      fladdr_q  <= 16'h0000;
      flwdata_q <= 8'h00;
      kind_q    <= CMD_NONE;
    end
    else
    begin
      req_q <= go && is_flash;
      if (go)
        kind_q <= new_cmd;
      if (go && is_flash)
      begin
        flwdata_q <= data_q;
        fladdr_q  <= addr;
        case (new_cmd)
          CMD_CHIP:  op_q <= FOP_CHIP;
          CMD_PART0: op_q <= FOP_PART0;
          CMD_SECT:
          begin
            op_q     <= FOP_SECT;
            fladdr_q <= addr & `FSQ_SECT_MASK;
          end
          CMD_PROG:  op_q <= FOP_PROG;
          default:   op_q <= FOP_READ;
        endcase
      end
    end
  end

  // erases that touch config commit once the array reports completion
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      apply_q     <= 1'b0;
      apply_cmd_q <= CMD_NONE;
    end
    else
    begin
      apply_q     <= (go && !is_flash)
                     || (op_end && (kind_q == CMD_CHIP || kind_q == CMD_PART0));
      apply_cmd_q <= go ? new_cmd : kind_q;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      cmd_q  <= `FSQ_REG_RST;
      ahi_q  <= `FSQ_REG_RST;
      alo_q  <= `FSQ_REG_RST;
      conf_q <= `FSQ_REG_RST;
    end
    else if (SFR_WR)
    begin
      if (SFR_ADDR == `FSQ_A_CMD)
        cmd_q <= SFR_WDATA;
      if (SFR_ADDR == `FSQ_A_AHI)
        ahi_q <= SFR_WDATA;
      if (SFR_ADDR == `FSQ_A_ALO)
        alo_q <= SFR_WDATA;
      if (SFR_ADDR == `FSQ_A_CONF)
        conf_q <= SFR_WDATA;
    end
  end

  // the verify result wins over a software write landing in the same cycle
  always_ff @(posedge CLK)
  begin
    if (SRST)
      data_q <= `FSQ_REG_RST;
    else if (op_end && kind_q == CMD_VERIFY)
      data_q <= FL_RDATA;
    else if (SFR_WR && SFR_ADDR == `FSQ_A_DATA)
      data_q <= SFR_WDATA;
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
      refused_q <= 1'b0;
    else if (wr_cmd)
      refused_q <= !go;
  end

  // keys are write-only; unmapped addresses read zero
  always_ff @(posedge CLK)
  begin
    if (SRST)
      rdata_q <= 8'h00;
    else
      case (SFR_ADDR)
        `FSQ_A_CMD:  rdata_q <= cmd_q;
        `FSQ_A_DATA: rdata_q <= data_q;
        `FSQ_A_AHI:  rdata_q <= ahi_q;
        `FSQ_A_ALO:  rdata_q <= alo_q;
        `FSQ_A_CONF: rdata_q <= conf_q;
        `FSQ_A_STAT: rdata_q <= {6'h00, refused_q, hold_q};
        default:     rdata_q <= 8'h00;
      endcase
  end

  assign cfg.apply     = apply_q;
  assign cfg.cmd       = apply_cmd_q;
  assign cfg.addr_high = ahi_q;
  assign cfg.data      = data_q;

  assign SFR_RDATA    = rdata_q;
  assign CPU_HOLD     = hold_q;
  assign FL_REQ       = req_q;
  assign FL_OP        = op_q;
  assign FL_ADDR      = fladdr_q;
  assign FL_WDATA     = flwdata_q;
  assign PAGE_LOCK_N  = cfg.lock_n;
  assign EXT_DISABLE  = cfg.ext_dis;
  assign CLOCK_DOUBLE = cfg.clk6;
  assign BOOT_MODE    = cfg.boot;
  assign BOOT_ADDR    = cfg.boot_addr;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);

  property p_feed;
    $rose(CPU_HOLD) |-> $past(state_q) == ST_KEY2 && $past(wr_cmd);
  endproperty
  a_feed: assert property (p_feed) else $error("operation without feed");

  property p_enable;
    FL_REQ |-> $past(conf_q[`FSQ_CONF_EN]);
  endproperty
  a_enable: assert property (p_enable) else $error("operation while disabled");

  property p_hold;
    FL_REQ |-> CPU_HOLD && state_q == ST_FLASH;
  endproperty
  a_hold: assert property (p_hold) else $error("cpu not held");

  property p_release;
    op_end |=> !CPU_HOLD && state_q == ST_IDLE;
  endproperty
  a_release: assert property (p_release) else $error("cpu not released");

  property p_lock;
    FL_REQ && (FL_OP == FOP_SECT || FL_OP == FOP_PROG || FL_OP == FOP_READ)
      |-> $past(cfg.lock_n[page_of(addr)]);
  endproperty
  a_lock: assert property (p_lock) else $error("locked page touched");

  property p_chip_pin;
    FL_REQ && FL_OP == FOP_CHIP |-> !$past(ea_n_s);
  endproperty
  a_chip_pin: assert property (p_chip_pin) else $error("chip erase with pin high");

  property p_sector;
    FL_REQ && FL_OP == FOP_SECT |-> FL_ADDR[6:0] == 7'h00;
  endproperty
  a_sector: assert property (p_sector) else $error("sector not aligned");

  property p_prog;
    FL_REQ && FL_OP == FOP_PROG |-> FL_WDATA == $past(data_q) && FL_ADDR == $past(addr);
  endproperty
  a_prog: assert property (p_prog) else $error("program address or data wrong");

  property p_verify;
    op_end && kind_q == CMD_VERIFY |=> data_q == $past(FL_RDATA);
  endproperty
  a_verify: assert property (p_verify) else $error("verify byte not returned");

  property p_cfg_quick;
    go && !is_flash |-> ##2 !CPU_HOLD && cfg.apply == 1'b0;
  endproperty
  a_cfg_quick: assert property (p_cfg_quick) else $error("config command stuck");

  c_chip: cover property (FL_REQ && FL_OP == FOP_CHIP);
  c_verify: cover property (op_end && kind_q == CMD_VERIFY);
  c_refused: cover property (wr_cmd && state_q == ST_KEY2 && !accept);
  c_secure: cover property (cfg.apply && cfg.cmd == CMD_SECURE);
endmodule : fsq_selfprog_sequencer

// ---- testbench/fsq_iap_sequencer_tb.sv ----
// self-checking bench for the flash command sequencer
`timescale 1ns/1ns
`include "fsq_consts.svh"
module testbench;
  import fsq_pkg::*;
  localparam logic [15:0] PB = 16'h4000;
  logic              CLK = 1'b0;
  logic              SRST = 1'b1;
  logic [7:0]        SFR_ADDR = 8'h00;
  logic              SFR_WR = 1'b0;
  logic [7:0]        SFR_WDATA = 8'h00;
  logic [7:0]        SFR_RDATA;
  logic              EXTERNAL_ACCESS_PIN_N = 1'b1;
  logic              CPU_HOLD;
  logic              FL_REQ;
  fsq_flop_t         FL_OP;
  logic [15:0]       FL_ADDR;
  logic [7:0]        FL_WDATA;
  logic              FL_DONE = 1'b0;
  logic [7:0]        FL_RDATA = 8'h00;
  logic [4:0]        PAGE_LOCK_N;
  logic [3:0]        EXT_DISABLE;
  logic              CLOCK_DOUBLE;
  fsq_boot_t         BOOT_MODE;
  logic [15:0]       BOOT_ADDR;
  int                n_mismatch = 0;
  int                n_tests = 0;
  int                seed = 32'h6d88;
  logic [53:0]       fl_q[$];
  logic [53:0]       e;
  logic [7:0]        rdv = 8'h00;

  fsq_selfprog_sequencer #(.PRIMARY_BYTES(PB)) dut (
    .CLK(CLK), .SRST(SRST), .SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR),
    .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA),
    .EXTERNAL_ACCESS_PIN_N(EXTERNAL_ACCESS_PIN_N), .CPU_HOLD(CPU_HOLD),
    .FL_REQ(FL_REQ), .FL_OP(FL_OP), .FL_ADDR(FL_ADDR), .FL_WDATA(FL_WDATA),
    .FL_DONE(FL_DONE), .FL_RDATA(FL_RDATA), .PAGE_LOCK_N(PAGE_LOCK_N),
    .EXT_DISABLE(EXT_DISABLE), .CLOCK_DOUBLE(CLOCK_DOUBLE),
    .BOOT_MODE(BOOT_MODE), .BOOT_ADDR(BOOT_ADDR)
  );

  always #20 CLK = ~CLK;

  task automatic chk(input logic [26:0] got, input logic [26:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic end_of_test;
    $display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test

  // one idle cycle after each write keeps the strobe from being set twice in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge CLK);
    SFR_ADDR = a;
    SFR_WDATA = d;
    SFR_WR = 1'b1;
    @(negedge CLK);
    SFR_WR = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge CLK);
    SFR_ADDR = a;
    @(negedge CLK);
    d = SFR_RDATA;
  endtask : rd

  task automatic mbox(input logic [7:0] ah, input logic [7:0] al, input logic [7:0] dt);
    wr(`FSQ_A_AHI, ah);
    wr(`FSQ_A_ALO, al);
    wr(`FSQ_A_DATA, dt);
  endtask : mbox

  // mask drops fields that the operation leaves unspecified
  task automatic expect_fl(input fsq_flop_t op, input logic [15:0] a, input logic [7:0] d,
                           input logic [26:0] m);
    fl_q.push_back({m, {op, a, d} & m});
  endtask : expect_fl

  task automatic cmd(input logic [6:0] code, input logic feed, input logic acc);
    int         n;
    logic [7:0] st;
    if (feed)
    begin
      wr(`FSQ_A_KEY1, `FSQ_KEY1_VAL);
      wr(`FSQ_A_KEY2, `FSQ_KEY2_VAL);
    end
    wr(`FSQ_A_CMD, {1'($random(seed)), code});
    n = 0;
    repeat (2) @(negedge CLK);
    while (CPU_HOLD !== 1'b0 && n < 100)
    begin
      @(negedge CLK);
      n++;
    end
    chk(27'(n == 100), 27'h0);
    repeat (3) @(negedge CLK);
    rd(`FSQ_A_STAT, st);
    chk(st[1:0], {~acc, 1'b0});
  endtask : cmd

  // array side: answers each request after a random stall
  initial
  begin
    forever
    begin
      @(negedge CLK);
      if (FL_REQ === 1'b1)
      begin
        if (fl_q.size() == 0)
          chk(27'h1, 27'h0);
        else
        begin
          e = fl_q.pop_front();
          chk({FL_OP, FL_ADDR, FL_WDATA} & e[53:27], e[26:0]);
        end
        chk(CPU_HOLD, 1'b1);
        // masked draw stays non-negative, so the stall is always 2 to 9 cycles
        repeat (2 + ($random(seed) & 7)) @(negedge CLK);
        FL_DONE = 1'b1;
        FL_RDATA = rdv;
        @(negedge CLK);
        FL_DONE = 1'b0;
        FL_RDATA = ~rdv;
      end
    end
  end

  initial
  begin
    #(40 * 20000);
    n_mismatch++;
    end_of_test();
  end

  initial
  begin
    logic [7:0]  v;
    logic [7:0]  t;
    logic [15:0] a;
    logic [4:0]  lk;
    logic [3:0]  ed;
    repeat (12) @(negedge CLK);
    SRST = 1'b0;
    chk({PAGE_LOCK_N, EXT_DISABLE, CLOCK_DOUBLE, CPU_HOLD}, {5'h1f, 6'h00});
    chk({BOOT_MODE, BOOT_ADDR}, {BOOT_DEF, PB});
    lk = 5'h1f;
    ed = 4'h0;
    a = 16'($random(seed)) & 16'h0fff;
    v = 8'($random(seed));
    mbox(a[15:8], a[7:0], v);
    cmd(`FSQ_C_PROG, 1'b1, 1'b0);
    wr(`FSQ_A_CONF, 8'h40);
    rd(`FSQ_A_AHI, t);
    chk(t, a[15:8]);
    rd(`FSQ_A_ALO, t);
    chk(t, a[7:0]);
    // erase before program, and verify only once the program has finished
    expect_fl(FOP_SECT, a & `FSQ_SECT_MASK, 8'h00, 27'h7ffff00);
    cmd(`FSQ_C_SECT, 1'b1, 1'b1);
    expect_fl(FOP_PROG, a, v, 27'h7ffffff);
    cmd(`FSQ_C_PROG, 1'b1, 1'b1);
    rdv = 8'($random(seed));
    expect_fl(FOP_READ, a, 8'h00, 27'h7ffff00);
    cmd(`FSQ_C_VERIFY, 1'b1, 1'b1);
    rd(`FSQ_A_DATA, t);
    chk(t, rdv);
    cmd(`FSQ_C_SECT, 1'b0, 1'b0);
    wr(`FSQ_A_KEY1, `FSQ_KEY1_VAL);
    wr(`FSQ_A_ALO, a[7:0]);
    wr(`FSQ_A_KEY2, `FSQ_KEY2_VAL);
    cmd(`FSQ_C_PROG, 1'b0, 1'b0);
    cmd(7'h02, 1'b1, 1'b0);
    mbox(8'h95, 8'h00, `FSQ_DKEY);
    cmd(`FSQ_C_SECURE, 1'b1, 1'b0);
    cmd(`FSQ_C_CHIP, 1'b1, 1'b0);
    for (int p = 0; p < 5; p++)
    begin
      mbox(8'h90 + 8'(p), 8'h00, 8'h00);
      cmd(`FSQ_C_SECURE, 1'b1, 1'b1);
      lk[p] = 1'b0;
      chk(PAGE_LOCK_N, lk);
      a = {2'b00, 2'(p), 12'($random(seed))};
      if (p == 4)
        a = PB | (16'($random(seed)) & 16'h03ff);
      mbox(a[15:8], a[7:0], 8'h00);
      cmd(`FSQ_C_PROG, 1'b1, 1'b0);
      cmd(`FSQ_C_SECT, 1'b1, 1'b0);
      cmd(`FSQ_C_VERIFY, 1'b1, 1'b0);
    end
    mbox(8'h00, 8'h00, `FSQ_DKEY);
    expect_fl(FOP_PART0, 16'h0000, 8'h00, 27'h7000000);
    cmd(`FSQ_C_PART0, 1'b1, 1'b1);
    lk[3:0] = 4'hf;
    chk(PAGE_LOCK_N, lk);
    for (int i = 0; i < 4; i++)
    begin
      mbox(8'hb0 + 8'(i), 8'h00, 8'h00);
      cmd(`FSQ_C_DISABLE, 1'b1, 1'b1);
      ed[i] = 1'b1;
      chk(EXT_DISABLE, ed);
    end
    mbox(`FSQ_AH_CLKDBL, 8'h00, 8'h00);
    cmd(`FSQ_C_MODE, 1'b1, 1'b1);
    chk(CLOCK_DOUBLE, 1'b1);
    v = 8'($random(seed));
    mbox(`FSQ_AH_SETVEC, 8'h00, v);
    cmd(`FSQ_C_SETVEC, 1'b1, 1'b1);
    mbox(`FSQ_AH_BUSER, 8'h00, 8'h00);
    cmd(`FSQ_C_MODE, 1'b1, 1'b1);
    chk({BOOT_MODE, BOOT_ADDR}, {BOOT_USER, v, 8'h00});
    mbox(`FSQ_AH_BZERO, 8'h00, 8'h00);
    cmd(`FSQ_C_MODE, 1'b1, 1'b1);
    chk({BOOT_MODE, BOOT_ADDR}, {BOOT_ZERO, 16'h0000});
    EXTERNAL_ACCESS_PIN_N = 1'b0;
    repeat (4) @(negedge CLK);
    mbox(8'h00, 8'h00, 8'h54);
    cmd(`FSQ_C_CHIP, 1'b1, 1'b0);
    mbox(8'h00, 8'h00, `FSQ_DKEY);
    expect_fl(FOP_CHIP, 16'h0000, 8'h00, 27'h7000000);
    cmd(`FSQ_C_CHIP, 1'b1, 1'b1);
    chk({PAGE_LOCK_N, EXT_DISABLE, CLOCK_DOUBLE}, {5'h1f, 4'h0, 1'b1});
    chk({BOOT_MODE, BOOT_ADDR}, {BOOT_DEF, PB});
    chk(27'(fl_q.size()), 27'h0);
    end_of_test();
  end
endmodule : testbench
